// ---- include/dcm_params.svh ----
// constants for the dma channel mode and request-source block
// assumes inclusion by the package, the single rtl module and the bench
// Operation
// - finished structure returns its mode to stopped
// - each channel structure holds one of six readable transfer modes
// - two structures per channel, picked by channel and primary/alternate
// - software may raise a request on any channel
// - software channel completion goes to the controller's own interrupt
// - peripheral channel completion goes to that peripheral's done line
// - one flag picks peripheral or memory task-list operation
// - per-channel source selector, default set by channel bitmask write
// - secondary selection stops requests from the default source
// - each muxed channel has one default and one secondary requester
// - remaining item count per structure falls as items move
// - finished structure reports zero remaining items
// - channel enable clears itself when its transfer completes
// - run-to-end finishes once started; request-driven moves only on request
// - double-buffer mode alternates between the two structures
`ifndef DCM_PARAMS_SVH
`define DCM_PARAMS_SVH
// ************************************************************
// register offsets
// ************************************************************
`define DCM_OFF_ENABLE 8'h00
`define DCM_OFF_SWREQ 8'h04
`define DCM_OFF_SEL_DEF 8'h08
`define DCM_OFF_SEL_SEC 8'h0C
`define DCM_OFF_SEL_STAT 8'h10
`define DCM_OFF_INT_STAT 8'h14
`define DCM_OFF_INT_MASK 8'h18
`define DCM_OFF_INDEX 8'h1C
`define DCM_OFF_KIND 8'h20
`define DCM_OFF_SRC 8'h24
`define DCM_OFF_DST 8'h28
`define DCM_OFF_COUNT 8'h2C
`define DCM_OFF_TL_START 8'h30
`define DCM_OFF_TL_LEN 8'h34
`define DCM_OFF_TL_CFG 8'h38
// ************************************************************
// fields and encodings
// ************************************************************
`define DCM_KIND_W 3
`define DCM_IDX_ALT_BIT 5
`define DCM_RESP_OKAY 2'b00
`define DCM_RESP_SLVERR 2'b10
`endif

// ---- include/dcm_pkg.sv ----
// types for the dma channel mode and request-source block
// assumes dcm_params.svh sits on the include path
`include "dcm_params.svh"
package dcm_pkg;
  // transfer kinds, gray coded along stop/request/run paths
  typedef enum logic [`DCM_KIND_W-1:0] {
    xfer_state_stopped = 3'h0,
    xfer_state_request_driven = 3'h1,
    xfer_state_run_to_end = 3'h3,
    xfer_state_double_buffer = 3'h2,
    xfer_state_memory_task_list = 3'h6,
    xfer_state_periph_task_list = 3'h7
  } dcm_kind_t;
endpackage

// ---- rtl/dcm_channel_ctrl.sv ----
// dma channel mode, item count, request-source mux and completion logic
// assumes an axi4-lite master, peripherals that hold request while ready
`timescale 1ns/1ns
`include "dcm_params.svh"
module dcm_channel_ctrl #(
  parameter int NCH = 32,
  parameter int CW = 16,
  parameter int SW_CH = 30
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NCH-1:0] default_source_req,
  input wire logic [NCH-1:0] secondary_source_req,
  output logic [NCH-1:0] default_source_done,
  output logic [NCH-1:0] secondary_source_done,
  output logic [NCH-1:0] item_strobe,
  output logic ctrl_irq
);
  localparam int IW = $clog2(NCH);
  // ************************************************************
  // per structure state: index = {alt, channel}
  // ************************************************************
  dcm_pkg::dcm_kind_t kind_r [2*NCH];
  logic [CW-1:0] count_r [2*NCH];
  logic [31:0] src_r [2*NCH];
  logic [31:0] dst_r [2*NCH];
  logic [NCH-1:0] enable_r;
  logic [NCH-1:0] sec_sel_r;
  logic [NCH-1:0] active_alt_r;
  logic [NCH-1:0] swreq_r;
  logic [NCH-1:0] run_r;
  logic [NCH-1:0] int_stat_r;
  logic [NCH-1:0] int_mask_r;
  logic [IW:0] index_r;
  logic [31:0] tl_start_r;
  logic [CW-1:0] tl_len_r;
  logic tl_periph_r;
  logic [NCH-1:0] done_nxt;
  logic [NCH-1:0] mv;
  logic [NCH-1:0] req_muxed;
  // ************************************************************
  // axi4-lite write channel
  // ************************************************************
  logic aw_hold_r, w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wr_go;
  logic [7:0] wa;
  logic [31:0] wd;
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign wa = aw_hold_r ? awaddr_r : s_axi_awaddr;
  assign wd = w_hold_r ? wdata_r : s_axi_wdata;
  assign wr_go = (aw_hold_r || (s_axi_awvalid && s_axi_awready)) &&
                 (w_hold_r || (s_axi_wvalid && s_axi_wready));
  // hold whichever half arrives first, answer once both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DCM_RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wa > `DCM_OFF_TL_CFG || wa[1:0] != 2'b00) ?
                       `DCM_RESP_SLVERR : `DCM_RESP_OKAY;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold_r <= 1'b1;
          awaddr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold_r <= 1'b1;
          wdata_r <= s_axi_wdata;
        end
        if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ************************************************************
  // channel level registers
  // ************************************************************
  logic wr_en, wr_swreq, wr_def, wr_sec, wr_istat;
  assign wr_en = wr_go && wa == `DCM_OFF_ENABLE;
  assign wr_swreq = wr_go && wa == `DCM_OFF_SWREQ;
  assign wr_def = wr_go && wa == `DCM_OFF_SEL_DEF;
  assign wr_sec = wr_go && wa == `DCM_OFF_SEL_SEC;
  assign wr_istat = wr_go && wa == `DCM_OFF_INT_STAT;
  // enable: set by write of ones, cleared at completion
  always_ff @(posedge aclk) begin
    if (!aresetn) enable_r <= '0;
    else enable_r <= (enable_r & ~done_nxt) | (wr_en ? wd[NCH-1:0] : '0);
  end
  // source selectors by bitmask: a one in either mask moves that channel
  always_ff @(posedge aclk) begin
    if (!aresetn) sec_sel_r <= '0;
    else if (wr_def) sec_sel_r <= sec_sel_r & ~wd[NCH-1:0];
    else if (wr_sec) sec_sel_r <= sec_sel_r | wd[NCH-1:0];
  end
  // software requests latch only on enabled channels
  always_ff @(posedge aclk) begin
    if (!aresetn) swreq_r <= '0;
    else swreq_r <= (swreq_r & enable_r & ~done_nxt) |
                    (wr_swreq ? wd[NCH-1:0] & enable_r : '0);
  end
  // controller interrupt: sticky, set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) int_stat_r <= '0;
    else int_stat_r <= (int_stat_r & ~(wr_istat ? wd[NCH-1:0] : '0)) |
                       (done_nxt & (NCH'(1) << SW_CH));
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) int_mask_r <= '0;
    else if (wr_go && wa == `DCM_OFF_INT_MASK) int_mask_r <= wd[NCH-1:0];
  end
  assign ctrl_irq = |(int_stat_r & int_mask_r);
  // ************************************************************
  // structure index and task list staging
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      index_r <= '0;
      tl_start_r <= 32'h0000_0000;
      tl_len_r <= '0;
    end else if (wr_go) begin
      if (wa == `DCM_OFF_INDEX)
        index_r <= {wd[`DCM_IDX_ALT_BIT], wd[IW-1:0]};
      else if (wa == `DCM_OFF_TL_START) tl_start_r <= wd;
      else if (wa == `DCM_OFF_TL_LEN) tl_len_r <= wd[CW-1:0];
    end
  end
  // ************************************************************
  // per channel request mux, movement and completion
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [IW:0] si;
      logic last;
      dcm_pkg::dcm_kind_t k;
      assign si = {active_alt_r[g], IW'(g)};
      assign k = kind_r[si];
      // only the selected source reaches the channel
      assign req_muxed[g] = sec_sel_r[g] ? secondary_source_req[g] :
                            default_source_req[g];
      assign last = count_r[si] == CW'(1);
      // request-driven moves only on request, run-to-end once started
      assign mv[g] = enable_r[g] && k != dcm_pkg::xfer_state_stopped &&
        count_r[si] != '0 && (req_muxed[g] || swreq_r[g] ||
        (run_r[g] && k != dcm_pkg::xfer_state_request_driven));
      assign done_nxt[g] = mv[g] && last &&
        !(k == dcm_pkg::xfer_state_double_buffer &&
          kind_r[{~active_alt_r[g], IW'(g)}] != dcm_pkg::xfer_state_stopped);
      // run-to-end latch and double-buffer structure toggling
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          run_r[g] <= 1'b0;
          active_alt_r[g] <= 1'b0;
        end else begin
          run_r[g] <= (run_r[g] || mv[g]) && !(mv[g] && last);
          if (mv[g] && last && k == dcm_pkg::xfer_state_double_buffer)
            active_alt_r[g] <= ~active_alt_r[g];
          else if (wr_en && wd[g] && !enable_r[g])
            active_alt_r[g] <= 1'b0;
        end
      end
      // completion pulse to the peripheral that served the channel
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          default_source_done[g] <= 1'b0;
          secondary_source_done[g] <= 1'b0;
          item_strobe[g] <= 1'b0;
        end else begin
          default_source_done[g] <= mv[g] && last && g != SW_CH &&
                                    !sec_sel_r[g];
          secondary_source_done[g] <= mv[g] && last && g != SW_CH &&
                                      sec_sel_r[g];
          item_strobe[g] <= mv[g];
        end
      end
    end
  endgenerate
  // ************************************************************
  // structure table: software writes and hardware countdown
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2*NCH; i++) begin
        kind_r[i] <= dcm_pkg::xfer_state_stopped;
        count_r[i] <= '0;
        src_r[i] <= 32'h0000_0000;
        dst_r[i] <= 32'h0000_0000;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (mv[c]) begin
          count_r[{active_alt_r[c], IW'(c)}] <=
            count_r[{active_alt_r[c], IW'(c)}] - CW'(1);
          if (count_r[{active_alt_r[c], IW'(c)}] == CW'(1))
            kind_r[{active_alt_r[c], IW'(c)}] <=
              dcm_pkg::xfer_state_stopped;
        end
      end
      if (wr_go) begin
        if (wa == `DCM_OFF_KIND)
          kind_r[index_r] <= dcm_pkg::dcm_kind_t'(wd[`DCM_KIND_W-1:0]);
        else if (wa == `DCM_OFF_SRC) src_r[index_r] <= wd;
        else if (wa == `DCM_OFF_DST) dst_r[index_r] <= wd;
        else if (wa == `DCM_OFF_COUNT) count_r[index_r] <= wd[CW-1:0];
        else if (wa == `DCM_OFF_TL_CFG) begin
          // task list loads the primary structure of the indexed channel
          kind_r[{1'b0, index_r[IW-1:0]}] <= wd[0] ?
            dcm_pkg::xfer_state_periph_task_list :
            dcm_pkg::xfer_state_memory_task_list;
          src_r[{1'b0, index_r[IW-1:0]}] <= tl_start_r;
          count_r[{1'b0, index_r[IW-1:0]}] <= tl_len_r;
        end
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) tl_periph_r <= 1'b0;
    else if (wr_go && wa == `DCM_OFF_TL_CFG) tl_periph_r <= wd[0];
  end
  // ************************************************************
  // axi4-lite read channel
  // ************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DCM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `DCM_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (s_axi_araddr == `DCM_OFF_ENABLE) s_axi_rdata <= 32'(enable_r);
      else if (s_axi_araddr == `DCM_OFF_SWREQ) s_axi_rdata <= 32'(swreq_r);
      else if (s_axi_araddr == `DCM_OFF_SEL_STAT)
        s_axi_rdata <= 32'(sec_sel_r);
      else if (s_axi_araddr == `DCM_OFF_INT_STAT)
        s_axi_rdata <= 32'(int_stat_r);
      else if (s_axi_araddr == `DCM_OFF_INT_MASK)
        s_axi_rdata <= 32'(int_mask_r);
      else if (s_axi_araddr == `DCM_OFF_INDEX)
        s_axi_rdata <= (32'(index_r[IW]) << `DCM_IDX_ALT_BIT) |
                       32'(index_r[IW-1:0]);
      else if (s_axi_araddr == `DCM_OFF_KIND)
        s_axi_rdata <= 32'(kind_r[index_r]);
      else if (s_axi_araddr == `DCM_OFF_SRC) s_axi_rdata <= src_r[index_r];
      else if (s_axi_araddr == `DCM_OFF_DST) s_axi_rdata <= dst_r[index_r];
      else if (s_axi_araddr == `DCM_OFF_COUNT)
        s_axi_rdata <= 32'(count_r[index_r]);
      else if (s_axi_araddr == `DCM_OFF_TL_START) s_axi_rdata <= tl_start_r;
      else if (s_axi_araddr == `DCM_OFF_TL_LEN) s_axi_rdata <= 32'(tl_len_r);
      else if (s_axi_araddr == `DCM_OFF_TL_CFG)
        s_axi_rdata <= 32'(tl_periph_r);
      else s_axi_rresp <= `DCM_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // dcm_channel_ctrl

// ---- verif/dcm_channel_ctrl_properties.sv ----
// port assertions for the dma channel control block
// assumes it is bound onto every dcm_channel_ctrl instance
`timescale 1ns/1ns
module dcm_channel_ctrl_chk #(
  parameter int NCH = 32,
  parameter int SW_CH = 30
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [NCH-1:0] default_source_done,
  input wire logic [NCH-1:0] secondary_source_done,
  input wire logic [NCH-1:0] item_strobe,
  input wire logic ctrl_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bus answers and refusals
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no bvalid");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no rvalid");
  wr_refuse_a: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  // completion lines
  sw_line_a: assert property (!default_source_done[SW_CH]
    && !secondary_source_done[SW_CH]) else $error("done on sw channel");
  one_source_a: assert property (
    (default_source_done & secondary_source_done) == '0) else $error("both");
  done_cause_a: assert property (((default_source_done
    | secondary_source_done) & ~(item_strobe | $past(item_strobe))) == '0)
    else $error("done without item");
  cover property (default_source_done != '0);
  cover property (secondary_source_done != '0);
  cover property ($rose(ctrl_irq));
endmodule // dcm_channel_ctrl_chk
bind dcm_channel_ctrl dcm_channel_ctrl_chk #(.NCH(NCH), .SW_CH(SW_CH))
  u_dcm_channel_ctrl_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .default_source_done(default_source_done),
  .secondary_source_done(secondary_source_done),
  .item_strobe(item_strobe), .ctrl_irq(ctrl_irq));

// ---- verif/dcm_periph_model.sv ----
// requesters on both sides of every channel source mux
// assumes the bench arms a request and the block answers with done
`timescale 1ns/1ns
module dcm_periph_model #(
  parameter int NCH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NCH-1:0] def_arm,
  input wire logic [NCH-1:0] sec_arm,
  input wire logic [NCH-1:0] default_source_done,
  input wire logic [NCH-1:0] secondary_source_done,
  output logic [NCH-1:0] default_source_req,
  output logic [NCH-1:0] secondary_source_req
);
  // a request level stands until its own done pulse comes back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      default_source_req <= '0;
      secondary_source_req <= '0;
    end else begin
      default_source_req <= (default_source_req | def_arm)
        & ~default_source_done;
      secondary_source_req <= (secondary_source_req | sec_arm)
        & ~secondary_source_done;
    end
  end
endmodule // dcm_periph_model

// ---- verif/dcm_channel_ctrl_tb.sv ----
// self-checking bench for the dma channel control block
// assumes dcm_pkg is compiled first and dcm_params.svh is on the path
`timescale 1ns/1ns
`include "dcm_params.svh"
module dma_channel_mode_mux_status_tb;
  localparam int SC = 30;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, irq;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv, dreq, sreq, ddone, sdone, strb, darm, sarm;
  logic [1:0] bresp, rresp, rr;
  int num_errors, n_checks, cyc, strobe_n, dn, sn;
  dcm_channel_ctrl #(.NCH(32), .CW(16), .SW_CH(SC)) u_dcm_channel_ctrl (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .default_source_req(dreq),
    .secondary_source_req(sreq), .default_source_done(ddone),
    .secondary_source_done(sdone), .item_strobe(strb), .ctrl_irq(irq));
  dcm_periph_model #(.NCH(32)) u_dcm_periph_model (.aclk(aclk),
    .aresetn(aresetn), .def_arm(darm), .sec_arm(sarm),
    .default_source_done(ddone), .secondary_source_done(sdone),
    .default_source_req(dreq), .secondary_source_req(sreq));
  // clock
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  // item and done tallies, hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    strobe_n <= strobe_n + $countones(strb);
    dn <= dn + $countones(ddone);
    sn <= sn + $countones(sdone);
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // bus write: each channel released at the edge it is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ok_a, ok_w;
    ok_a = 1'h0;
    ok_w = 1'h0;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    while (!(ok_a && ok_w)) begin
      @(posedge aclk);
      ok_a = ok_a | awready;
      ok_w = ok_w | wready;
      if (ok_a) awvalid <= 1'h0;
      if (ok_w) wvalid <= 1'h0;
    end
    do @(posedge aclk); while (!bvalid);
    rr = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    rv = rdata;
    rr = rresp;
  endtask
  task automatic sel(input int ch, input int alt);
    wr(`DCM_OFF_INDEX, 32'(ch + (alt << `DCM_IDX_ALT_BIT)));
  endtask
  task automatic wait_off(input int ch);
    rd(`DCM_OFF_ENABLE);
    for (int k = 0; k < 40 && rv[ch] !== 1'h0; k++) rd(`DCM_OFF_ENABLE);
    chk({31'h0, rv[ch]}, 32'h0);
  endtask
  task automatic t_kinds();
    dcm_pkg::dcm_kind_t ks[6];
    ks = '{dcm_pkg::xfer_state_stopped, dcm_pkg::xfer_state_request_driven,
      dcm_pkg::xfer_state_run_to_end, dcm_pkg::xfer_state_double_buffer,
      dcm_pkg::xfer_state_memory_task_list,
      dcm_pkg::xfer_state_periph_task_list};
    for (int i = 0; i < 6; i++) begin
      sel(7, 0);
      wr(`DCM_OFF_KIND, 32'(ks[i]));
      sel(7, 1);
      wr(`DCM_OFF_KIND, 32'(ks[5-i]));
      sel(7, 0);
      rd(`DCM_OFF_KIND);
      chk(rv, 32'(ks[i]));
      sel(7, 1);
      rd(`DCM_OFF_KIND);
      chk(rv, 32'(ks[5-i]));
    end
    $display("test kinds done");
  endtask
  task automatic t_sw();
    int s0;
    s0 = strobe_n;
    sel(SC, 0);
    wr(`DCM_OFF_KIND, 32'(dcm_pkg::xfer_state_run_to_end));
    wr(`DCM_OFF_COUNT, 32'h2);
    wr(`DCM_OFF_SWREQ, 32'h1 << SC);
    repeat (5) @(posedge aclk);
    rd(`DCM_OFF_COUNT);
    chk(rv, 32'h2);
    wr(`DCM_OFF_INT_MASK, 32'h1 << SC);
    wr(`DCM_OFF_ENABLE, 32'h1 << SC);
    wr(`DCM_OFF_SWREQ, 32'h1 << SC);
    wait_off(SC);
    rd(`DCM_OFF_COUNT);
    chk(rv, 32'h0);
    rd(`DCM_OFF_KIND);
    chk(rv, 32'h0);
    chk(32'(strobe_n - s0), 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(`DCM_OFF_INT_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`DCM_OFF_INT_MASK, 32'h1 << SC);
    wr(`DCM_OFF_INT_STAT, 32'h1 << SC);
    chk({31'h0, irq}, 32'h0);
    $display("test sw channel done");
  endtask
  task automatic t_mux();
    int s0, s1;
    s0 = sn;
    s1 = dn;
    wr(`DCM_OFF_SEL_SEC, 32'h20);
    rd(`DCM_OFF_SEL_STAT);
    chk(rv, 32'h20);
    sel(5, 0);
    wr(`DCM_OFF_KIND, 32'(dcm_pkg::xfer_state_request_driven));
    wr(`DCM_OFF_COUNT, 32'h3);
    wr(`DCM_OFF_ENABLE, 32'h20);
    darm <= 32'h20;
    @(posedge aclk);
    darm <= 32'h0;
    repeat (8) @(posedge aclk);
    rd(`DCM_OFF_COUNT);
    chk(rv, 32'h3);
    sarm <= 32'h20;
    @(posedge aclk);
    sarm <= 32'h0;
    wait_off(5);
    chk(32'(sn - s0), 32'h1);
    wr(`DCM_OFF_SEL_DEF, 32'h20);
    rd(`DCM_OFF_SEL_STAT);
    chk(rv, 32'h0);
    wr(`DCM_OFF_KIND, 32'(dcm_pkg::xfer_state_request_driven));
    wr(`DCM_OFF_COUNT, 32'h1);
    wr(`DCM_OFF_ENABLE, 32'h20);
    wait_off(5);
    chk(32'(dn - s1), 32'h1);
    $display("test source mux done");
  endtask
  // double buffer: primary then alternate, enable held across the switch
  task automatic t_pp();
    int s0;
    s0 = strobe_n;
    sel(3, 0);
    wr(`DCM_OFF_KIND, 32'(dcm_pkg::xfer_state_double_buffer));
    wr(`DCM_OFF_COUNT, 32'h2);
    sel(3, 1);
    wr(`DCM_OFF_KIND, 32'(dcm_pkg::xfer_state_double_buffer));
    wr(`DCM_OFF_COUNT, 32'h2);
    wr(`DCM_OFF_ENABLE, 32'h8);
    wr(`DCM_OFF_SWREQ, 32'h8);
    wait_off(3);
    rd(`DCM_OFF_COUNT);
    chk(rv, 32'h0);
    rd(`DCM_OFF_KIND);
    chk(rv, 32'h0);
    sel(3, 0);
    rd(`DCM_OFF_KIND);
    chk(rv, 32'h0);
    chk(32'(strobe_n - s0), 32'h4);
    $display("test double buffer done");
  endtask
  task automatic t_tl();
    sel(9, 0);
    wr(`DCM_OFF_TL_START, 32'h100);
    wr(`DCM_OFF_TL_LEN, 32'h5);
    wr(`DCM_OFF_TL_CFG, 32'h1);
    rd(`DCM_OFF_KIND);
    chk(rv, 32'(dcm_pkg::xfer_state_periph_task_list));
    rd(`DCM_OFF_COUNT);
    chk(rv, 32'h5);
    rd(`DCM_OFF_SRC);
    chk(rv, 32'h100);
    wr(`DCM_OFF_TL_CFG, 32'h0);
    rd(`DCM_OFF_KIND);
    chk(rv, 32'(dcm_pkg::xfer_state_memory_task_list));
    $display("test task list done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, darm, sarm} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h3C);
    chk({30'h0, rr}, {30'h0, `DCM_RESP_SLVERR});
    rd(`DCM_OFF_ENABLE);
    chk(rv, 32'h0);
    t_kinds();
    t_sw();
    t_mux();
    t_pp();
    t_tl();
    close_out();
  end
endmodule // dma_channel_mode_mux_status_tb
